// ---- logic/aer_pkg.sv ----
// constants and carrier types for the error reporting register bank
package aer_pkg;
  // byte addresses on the register bus
  localparam logic [9:0] UNC_STATUS_OFS = 10'h104;
  localparam logic [9:0] UNC_MASK_OFS   = 10'h108;
  localparam logic [9:0] UNC_SEV_OFS    = 10'h10C;
  localparam logic [9:0] COR_STATUS_OFS = 10'h110;
  localparam logic [9:0] COR_MASK_OFS   = 10'h114;
  localparam logic [9:0] CAP_CTRL_OFS   = 10'h118;
  localparam logic [9:0] HDR_LOG0_OFS   = 10'h11C;
  localparam logic [9:0] HDR_LOG3_OFS   = 10'h128;
  localparam logic [9:0] IRQ_STATUS_OFS = 10'h140;
  localparam logic [9:0] IRQ_ENABLE_OFS = 10'h144;
  localparam logic [9:0] IRQ_CLEAR_OFS  = 10'h148;
  // implemented bits of each register, plus the severity reset value
  localparam logic [31:0] UNC_IMPL  = 32'h001FF010;
  localparam logic [31:0] SEV_RW    = 32'h001FF010;
  localparam logic [31:0] SEV_RESET = 32'h00062010;
  localparam logic [31:0] COR_IMPL  = 32'h000031C1;
  // capability and control field positions
  localparam int FEP_LSB     = 0;
  localparam int GEN_CAP_BIT = 5;
  localparam int GEN_EN_BIT  = 6;
  localparam int CHK_CAP_BIT = 7;
  localparam int CHK_EN_BIT  = 8;
  localparam logic [4:0] FEP_RESET = 5'h00;
  localparam logic [2:0] IRQ_UNC_BIT = 3'h0;
  // interrupt status layout: 0 unc fatal, 1 unc non-fatal, 2 correctable
  localparam int IRQ_W = 3;

  typedef struct packed {
    logic [9:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } bus_req_t;

  typedef struct packed {
    logic [3:0][31:0] words;   // word 0 holds header bytes 0..3
  } tlp_hdr_t;
endpackage

// ---- logic/advanced_error_reporting_regs.sv ----
// error reporting register bank with memory-mapped slave and interrupt
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/10ps
module advanced_error_reporting_regs #(
  parameter logic ECRC_GEN_CAPABLE = 1'b1,
  parameter logic ECRC_CHK_CAPABLE = 1'b1
) (
  input  wire logic              clk,             // core clock 50 mhz
  input  wire logic              rst,             // full core reset
  input  wire logic              link_rst,        // link-level reset
  input  wire aer_pkg::bus_req_t bus_req,         // register bus request
  output logic                   waitrequest,     // register bus stall
  output logic [31:0]            readdata,        // register bus read data
  input  wire logic [31:0]       unc_event,       // uncorrectable pulses
  input  wire logic [31:0]       cor_event,       // correctable pulses
  input  wire aer_pkg::tlp_hdr_t err_hdr,         // header of bad tlp
  output logic                   fatal_msg,       // fatal report pulse
  output logic                   nonfatal_msg,    // non-fatal report pulse
  output logic                   cor_msg,         // correctable pulse
  output logic                   unc_forward,     // severe error pulse
  output logic                   ecrc_gen_en,     // ecrc generation on
  output logic                   ecrc_chk_en,     // ecrc check on
  output logic                   irq              // level interrupt
);
  logic [31:0]         unc_status_ff, unc_mask_ff, sev_ff;
  logic [31:0]         cor_status_ff, cor_mask_ff;
  logic [4:0]          fep_ff;
  logic                gen_en_ff, chk_en_ff;
  aer_pkg::tlp_hdr_t   hdr_ff;
  logic [2:0]          irq_st_ff, irq_en_ff;
  logic                ack_ff;
  logic [31:0]         nxt_readdata;
  logic                wr, rd;
  logic [31:0]         wd, unc_new, cor_new;
  logic [4:0]          nxt_fep;
  logic                fatal_ev, nonfatal_ev, cor_ev;

  // notes for whoever integrates this bank:
  // - every access costs exactly one wait cycle, reads and writes alike;
  //   a master that holds its request until waitrequest falls needs no
  //   knowledge of this, but a burst of accesses runs at half rate.
  // - status bits record an event even while its mask bit is set; the
  //   mask holds back the message pulses, the interrupt cause and the pointer and header log capture.
  //   software that unmasks later must clear stale status first.
  // - an event in the same cycle as a software clear wins, so no event
  //   can slip past between a read and the clear that follows it.
  // - the pointer and header log are sticky: link reset keeps them and
  //   only the full core reset wipes them, so a host can read the cause
  //   of a failure after the link has retrained.
  // - the header is taken as one whole capture; a second error while the
  //   pointed-to status bit stays set leaves the log alone, which keeps
  //   the oldest cause rather than the newest.
  // - message outputs are one-cycle pulses one edge after the event;
  //   the consumer must not drop a cycle or a report is lost.
  // - link reset clears masks, severities and ecrc enables to defaults,
  //   matching what configuration software expects after retraining.

  // one wait cycle per access: ack rises the cycle after the request
  assign waitrequest = (bus_req.read | bus_req.write) & ~ack_ff;
  assign wr = bus_req.write & ack_ff;
  assign rd = bus_req.read & ack_ff;
  assign wd = bus_req.writedata;

  // access handshake
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (bus_req.read | bus_req.write) & ~ack_ff;
    end
  end

  // unmasked new events
  assign unc_new = unc_event & aer_pkg::UNC_IMPL & ~unc_mask_ff;
  assign cor_new = cor_event & aer_pkg::COR_IMPL & ~cor_mask_ff;
  assign fatal_ev    = |(unc_new & ~sev_ff);
  assign nonfatal_ev = |(unc_new & sev_ff);
  assign cor_ev      = |cor_new;

  // lowest set bit picks the pointer when several errors coincide;
  // the loop runs from the top so the last hit, the lowest bit, stays.
  // a fixed order was chosen over arrival order because coinciding
  // events carry no order of their own inside one cycle.
  always_comb begin
    nxt_fep = aer_pkg::FEP_RESET;
    for (int i = 31; i >= 0; i--) begin
      if (unc_new[i]) begin
        nxt_fep = 5'(i);
      end
    end
  end

  // uncorrectable status: event set wins over software clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      unc_status_ff <= 32'h00000000;
    end else begin
      unc_status_ff <= ((unc_status_ff & ~((wr &&
        bus_req.address == aer_pkg::UNC_STATUS_OFS) ? wd : 32'h00000000))
        | unc_event) & aer_pkg::UNC_IMPL;
    end
  end

  // correctable status, same set-over-clear ordering
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cor_status_ff <= 32'h00000000;
    end else begin
      cor_status_ff <= ((cor_status_ff & ~((wr &&
        bus_req.address == aer_pkg::COR_STATUS_OFS) ? wd : 32'h00000000))
        | cor_event) & aer_pkg::COR_IMPL;
    end
  end

  // masks and severity; link reset returns non-sticky controls to default
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      unc_mask_ff <= 32'h00000000;
      cor_mask_ff <= 32'h00000000;
      sev_ff      <= aer_pkg::SEV_RESET;
      gen_en_ff   <= 1'b0;
      chk_en_ff   <= 1'b0;
    end else if (link_rst) begin
      unc_mask_ff <= 32'h00000000;
      cor_mask_ff <= 32'h00000000;
      sev_ff      <= aer_pkg::SEV_RESET;
      gen_en_ff   <= 1'b0;
      chk_en_ff   <= 1'b0;
    end else if (wr) begin
      case (bus_req.address)
        aer_pkg::UNC_MASK_OFS: unc_mask_ff <= wd & aer_pkg::UNC_IMPL;
        aer_pkg::COR_MASK_OFS: cor_mask_ff <= wd & aer_pkg::COR_IMPL;
        aer_pkg::UNC_SEV_OFS:  sev_ff <= wd & aer_pkg::SEV_RW;
        aer_pkg::CAP_CTRL_OFS: begin
          gen_en_ff <= wd[aer_pkg::GEN_EN_BIT];
          chk_en_ff <= wd[aer_pkg::CHK_EN_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // sticky pointer and header log: only full reset clears them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fep_ff <= aer_pkg::FEP_RESET;
      hdr_ff <= '0;
    end else if (|unc_new && !unc_status_ff[fep_ff]) begin
      fep_ff <= nxt_fep;
      hdr_ff <= err_hdr;
    end
  end

  // interrupt causes: sticky, recorded whatever the enable, write-one clear, set wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_st_ff <= 3'h0;
      irq_en_ff <= 3'h0;
    end else begin
      irq_st_ff <= (irq_st_ff & ~((wr &&
        bus_req.address == aer_pkg::IRQ_CLEAR_OFS) ? wd[2:0] : 3'h0))
        | {cor_ev, nonfatal_ev, fatal_ev};
      if (wr && bus_req.address == aer_pkg::IRQ_ENABLE_OFS) begin
        irq_en_ff <= wd[2:0];
      end
    end
  end

  // message pulses follow the detecting cycle by one edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fatal_msg    <= 1'b0;
      nonfatal_msg <= 1'b0;
      cor_msg      <= 1'b0;
      unc_forward  <= 1'b0;
    end else begin
      fatal_msg    <= fatal_ev;
      nonfatal_msg <= nonfatal_ev;
      cor_msg      <= cor_ev;
      unc_forward  <= |unc_new;
    end
  end

  assign ecrc_gen_en = gen_en_ff;
  assign ecrc_chk_en = chk_en_ff;
  assign irq = |(irq_st_ff & irq_en_ff);

  // read mux; unmapped addresses read zero
  always_comb begin
    nxt_readdata = 32'h00000000;
    case (bus_req.address)
      aer_pkg::UNC_STATUS_OFS: nxt_readdata = unc_status_ff;
      aer_pkg::UNC_MASK_OFS:   nxt_readdata = unc_mask_ff;
      aer_pkg::UNC_SEV_OFS:    nxt_readdata = sev_ff;
      aer_pkg::COR_STATUS_OFS: nxt_readdata = cor_status_ff;
      aer_pkg::COR_MASK_OFS:   nxt_readdata = cor_mask_ff;
      aer_pkg::CAP_CTRL_OFS: begin
        nxt_readdata[aer_pkg::FEP_LSB +: 5]   = fep_ff;
        nxt_readdata[aer_pkg::GEN_CAP_BIT]    = ECRC_GEN_CAPABLE;
        nxt_readdata[aer_pkg::GEN_EN_BIT]     = gen_en_ff;
        nxt_readdata[aer_pkg::CHK_CAP_BIT]    = ECRC_CHK_CAPABLE;
        nxt_readdata[aer_pkg::CHK_EN_BIT]     = chk_en_ff;
      end
      aer_pkg::IRQ_STATUS_OFS: nxt_readdata = {29'h0, irq_st_ff};
      aer_pkg::IRQ_ENABLE_OFS: nxt_readdata = {29'h0, irq_en_ff};
      default: begin
        if (bus_req.address >= aer_pkg::HDR_LOG0_OFS &&
            bus_req.address <= aer_pkg::HDR_LOG3_OFS &&
            bus_req.address[1:0] == 2'h0) begin
          nxt_readdata = hdr_ff.words[2'(bus_req.address[3:2] - 2'h3)];
        end
      end
    endcase
  end

  // read data registered so it stands at the accepting edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata <= 32'h00000000;
    end else begin
      readdata <= nxt_readdata;
    end
  end

  // checks
  clear_one_a: assert property (@(posedge clk) disable iff (rst)
    (wr && bus_req.address == aer_pkg::UNC_STATUS_OFS && wd[20] &&
     !unc_event[20]) |=> !unc_status_ff[20])
    else $error("w1c failed to clear");
  set_sticks_a: assert property (@(posedge clk) disable iff (rst)
    unc_event[18] |=> unc_status_ff[18])
    else $error("uncorrectable event lost");
  cor_set_a: assert property (@(posedge clk) disable iff (rst)
    cor_event[0] |=> cor_status_ff[0])
    else $error("correctable event lost");
  rsvd_zero_a: assert property (@(posedge clk) disable iff (rst)
    (unc_status_ff & ~aer_pkg::UNC_IMPL) == 0)
    else $error("reserved status bit set");
  fatal_sev_a: assert property (@(posedge clk) disable iff (rst)
    (unc_new[18] && !sev_ff[18]) |=> fatal_msg)
    else $error("fatal not reported");
  mask_block_a: assert property (@(posedge clk) disable iff (rst)
    (unc_event == 32'h00100000 && unc_mask_ff[20]) |=> !unc_forward)
    else $error("masked error forwarded");
  sev_ro_a: assert property (@(posedge clk) disable iff (rst)
    !sev_ff[5])
    else $error("surprise down severity written");
  hdr_hold_a: assert property (@(posedge clk) disable iff (rst)
    (unc_status_ff[fep_ff] && $stable(fep_ff)) |=> $stable(hdr_ff))
    else $error("header log overwritten");
  sticky_link_a: assert property (@(posedge clk) disable iff (rst)
    (link_rst && unc_new == 0) |=> $stable(fep_ff))
    else $error("pointer lost on link reset");
  wait_one_a: assert property (@(posedge clk) disable iff (rst)
    (bus_req.read && waitrequest) |=> !waitrequest)
    else $error("answer late");
  // a write of one clears a correctable bit when no event races it
  cor_clear_a: assert property (
    @(posedge clk) disable iff (rst)
    (wr && bus_req.address == aer_pkg::COR_STATUS_OFS && wd[0] &&
     !cor_event[0]) |=> !cor_status_ff[0])
    else $error("correctable w1c failed to clear");

  // reserved correctable status bits never rise
  cor_rsvd_a: assert property (
    @(posedge clk) disable iff (rst)
    (cor_status_ff & ~aer_pkg::COR_IMPL) == 32'h00000000)
    else $error("reserved correctable bit set");

  // reserved correctable mask bits stay zero whatever is written
  cmask_rsvd_a: assert property (
    @(posedge clk) disable iff (rst)
    (cor_mask_ff & ~aer_pkg::COR_IMPL) == 32'h00000000)
    else $error("reserved correctable mask bit set");

  // reserved uncorrectable mask bits stay zero
  umask_rsvd_a: assert property (
    @(posedge clk) disable iff (rst)
    (unc_mask_ff & ~aer_pkg::UNC_IMPL) == 32'h00000000)
    else $error("reserved uncorrectable mask bit set");

  // only the writable severity bits may ever be one
  sev_rsvd_a: assert property (
    @(posedge clk) disable iff (rst)
    (sev_ff & ~aer_pkg::SEV_RW) == 32'h00000000)
    else $error("reserved severity bit set");

  // severity one turns an unmasked error into a non-fatal report
  nonfatal_sev_a: assert property (
    @(posedge clk) disable iff (rst)
    (unc_new[18] && sev_ff[18]) |=> nonfatal_msg)
    else $error("non-fatal not reported");

  // every unmasked uncorrectable error is forwarded as severe
  forward_a: assert property (
    @(posedge clk) disable iff (rst)
    (|unc_new) |=> unc_forward)
    else $error("unmasked error not forwarded");

  // an unmasked correctable event is reported one edge later
  cor_pulse_a: assert property (
    @(posedge clk) disable iff (rst)
    (|cor_new) |=> cor_msg)
    else $error("correctable not reported");

  // the pointer takes the new error while the old one is cleared
  fep_load_a: assert property (
    @(posedge clk) disable iff (rst)
    (|unc_new && !unc_status_ff[fep_ff]) |=> fep_ff == $past(nxt_fep))
    else $error("pointer not loaded");

  // the header log captures the offending header with the pointer
  hdr_load_a: assert property (
    @(posedge clk) disable iff (rst)
    (|unc_new && !unc_status_ff[fep_ff]) |=> hdr_ff == $past(err_hdr))
    else $error("header not captured");

  // link reset returns the uncorrectable mask, severity and ecrc generation enable to their defaults
  link_ctl_a: assert property (
    @(posedge clk) disable iff (rst)
    link_rst |=> (unc_mask_ff == 32'h00000000 &&
                  sev_ff == aer_pkg::SEV_RESET && !ecrc_gen_en))
    else $error("link reset left controls set");

  // capable flags and reserved bits of the control word read fixed
  cap_fixed_a: assert property (
    @(posedge clk) disable iff (rst)
    (bus_req.read && bus_req.address == aer_pkg::CAP_CTRL_OFS) |=>
    (readdata[aer_pkg::GEN_CAP_BIT] == ECRC_GEN_CAPABLE &&
     readdata[aer_pkg::CHK_CAP_BIT] == ECRC_CHK_CAPABLE &&
     readdata[31:9] == 23'h000000))
    else $error("control word fixed bits wrong");

  // a fatal report leaves its interrupt cause behind
  irq_set_a: assert property (
    @(posedge clk) disable iff (rst)
    fatal_ev |=> irq_st_ff[0])
    else $error("fatal cause not recorded");

  // writes get the same single wait cycle as reads
  wait_wr_a: assert property (@(posedge clk) disable iff (rst)
    (bus_req.write && waitrequest) |=> !waitrequest)
    else $error("write answer late");

  // the data link protocol event lands in bit 4
  dl_set_a: assert property (
    @(posedge clk) disable iff (rst)
    unc_event[4] |=> unc_status_ff[4])
    else $error("data link event lost");

  // the advisory event lands in bit 13
  adv_set_a: assert property (
    @(posedge clk) disable iff (rst)
    cor_event[13] |=> cor_status_ff[13])
    else $error("advisory event lost");

  // main scenarios reached
  fatal_c: cover property (@(posedge clk) disable iff (rst) fatal_msg);
  cor_c: cover property (@(posedge clk) disable iff (rst) cor_msg);
  masked_c: cover property (@(posedge clk) disable iff (rst)
    unc_event[20] && unc_mask_ff[20]);
  nonfatal_c: cover property (@(posedge clk) disable iff (rst) nonfatal_msg);
  irq_c: cover property (@(posedge clk) disable iff (rst) irq);
endmodule // advanced_error_reporting_regs

// ---- test/err_source.sv ----
// error detector model that raises event pulses with the offending header
`timescale 1ns/10ps
module err_source (
  input  wire logic         clk,        // core clock
  output logic [31:0]       unc_event,  // uncorrectable pulses
  output logic [31:0]       cor_event,  // correctable pulses
  output aer_pkg::tlp_hdr_t err_hdr     // header of the bad tlp
);
  // quiet lines at time zero
  initial begin
    unc_event = 32'h0;
    cor_event = 32'h0;
    err_hdr   = '0;
  end
  // one-cycle pulse; header inverted after so stale data never matches
  task automatic fire(input logic [31:0] unc, input logic [31:0] cor,
                      input aer_pkg::tlp_hdr_t h);
    @(posedge clk);
    unc_event <= unc;
    cor_event <= cor;
    err_hdr   <= h;
    @(posedge clk);
    unc_event <= 32'h0;
    cor_event <= 32'h0;
    err_hdr   <= ~h;
  endtask
endmodule // err_source

// ---- test/advanced_error_reporting_regs_tb.sv ----
// self-checking bench for the error reporting register bank
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD %0t got %h exp %h", $time, a, b); end end
module advanced_error_reporting_regs_tb;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              link_rst = 1'b0;
  aer_pkg::bus_req_t bus_req = '0;
  logic              waitrequest, fatal_msg, nonfatal_msg, cor_msg, irq;
  logic              unc_forward, ecrc_gen_en, ecrc_chk_en;
  logic [31:0]       readdata, unc_event, cor_event, rv;
  aer_pkg::tlp_hdr_t err_hdr, h;
  int n_fail = 0, compares = 0, cyc = 0, e_fat = 0, e_nf = 0;
  int n_fat = 0, n_nf = 0, n_cor = 0, n_fw = 0;
  int ub[10] = '{20, 19, 18, 17, 16, 15, 14, 13, 12, 4};
  int cb[6]  = '{13, 12, 8, 7, 6, 0};

  advanced_error_reporting_regs u_advanced_error_reporting_regs (
    .clk(clk), .rst(rst), .link_rst(link_rst), .bus_req(bus_req),
    .waitrequest(waitrequest), .readdata(readdata),
    .unc_event(unc_event), .cor_event(cor_event), .err_hdr(err_hdr),
    .fatal_msg(fatal_msg), .nonfatal_msg(nonfatal_msg),
    .cor_msg(cor_msg), .unc_forward(unc_forward),
    .ecrc_gen_en(ecrc_gen_en), .ecrc_chk_en(ecrc_chk_en), .irq(irq));
  err_source u_err_source (
    .clk(clk), .unc_event(unc_event), .cor_event(cor_event),
    .err_hdr(err_hdr));

  always #10 clk = ~clk;
  // report pulses are counted, so their exact cycle never races a read
  always @(posedge clk) begin
    cyc++;
    n_fat += (fatal_msg === 1'b1);
    n_nf  += (nonfatal_msg === 1'b1);
    n_cor += (cor_msg === 1'b1);
    n_fw  += (unc_forward === 1'b1);
    if (cyc == 6000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("fails %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one bus cycle held until waitrequest low, then an idle edge
  task automatic access(input logic [9:0] a, input logic w,
                        input logic [31:0] d);
    logic stall;
    stall = 1'b1;
    bus_req <= '{address: a, read: !w, write: w, writedata: d};
    // answer read settled mid-cycle; the request ends at the next rise
    while (stall) begin
      @(negedge clk);
      stall = (waitrequest !== 1'b0);
      rv = readdata;
      @(posedge clk);
    end
    bus_req <= '0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    access(a, 1'b1, d);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    access(a, 1'b0, 32'h0);
    `CHK(rv, e)
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // defaults, then every mask, severity and control bit, then masks and severity back to defaults on link reset
    rd(aer_pkg::UNC_SEV_OFS, aer_pkg::SEV_RESET);
    rd(aer_pkg::CAP_CTRL_OFS, 32'h000000A0);
    rd(aer_pkg::HDR_LOG3_OFS, 32'h0);
    rd(10'h1F0, 32'h0);
    wr(aer_pkg::UNC_MASK_OFS, '1);
    rd(aer_pkg::UNC_MASK_OFS, aer_pkg::UNC_IMPL);
    wr(aer_pkg::COR_MASK_OFS, '1);
    rd(aer_pkg::COR_MASK_OFS, aer_pkg::COR_IMPL);
    wr(aer_pkg::UNC_SEV_OFS, '1);
    rd(aer_pkg::UNC_SEV_OFS, aer_pkg::SEV_RW);
    wr(aer_pkg::CAP_CTRL_OFS, '1);
    rd(aer_pkg::CAP_CTRL_OFS, 32'h000001E0);
    `CHK({ecrc_gen_en, ecrc_chk_en}, 2'b11)
    link_rst <= 1'b1;
    @(posedge clk);
    link_rst <= 1'b0;
    @(posedge clk);
    rd(aer_pkg::UNC_MASK_OFS, 32'h0);
    rd(aer_pkg::COR_MASK_OFS, 32'h0);
    rd(aer_pkg::UNC_SEV_OFS, aer_pkg::SEV_RESET);
    wr(aer_pkg::IRQ_ENABLE_OFS, 32'h7);
    // each uncorrectable event alone: status, pointer, log, clear
    for (int i = 0; i < 10; i++) begin
      for (int k = 0; k < 4; k++) h.words[k] = {8'(ub[i]), 8'(k), 16'h5AC3};
      u_err_source.fire(32'h1 << ub[i], 32'h0, h);
      rd(aer_pkg::UNC_STATUS_OFS, 32'h1 << ub[i]);
      rd(aer_pkg::CAP_CTRL_OFS, 32'hA0 | 32'(ub[i]));
      for (int k = 0; k < 4; k++)
        rd(aer_pkg::HDR_LOG0_OFS + 10'(4 * k), h.words[k]);
      wr(aer_pkg::UNC_STATUS_OFS, 32'h1 << ub[i]);
      rd(aer_pkg::UNC_STATUS_OFS, 32'h0);
      if (aer_pkg::SEV_RESET[ub[i]]) e_nf++;
      else e_fat++;
    end
    `CHK(n_fat, e_fat)
    `CHK(n_nf, e_nf)
    `CHK(n_fw, 10)
    rd(aer_pkg::IRQ_STATUS_OFS, 32'h3);
    `CHK(irq, 1'b1)
    wr(aer_pkg::IRQ_CLEAR_OFS, 32'h7);
    `CHK(irq, 1'b0)
    // masked error sets status but reports nothing
    wr(aer_pkg::UNC_MASK_OFS, 32'h00100000);
    u_err_source.fire(32'h00100000, 32'h0, h);
    rd(aer_pkg::UNC_STATUS_OFS, 32'h00100000);
    `CHK(n_fat + n_nf, e_fat + e_nf)
    wr(aer_pkg::UNC_STATUS_OFS, '1);
    // a second error while the first is pending leaves pointer and log
    u_err_source.fire(32'h00080000, 32'h0, h);
    u_err_source.fire(32'h00040000, 32'h0, ~h);
    rd(aer_pkg::CAP_CTRL_OFS, 32'h000000B3);
    link_rst <= 1'b1;
    @(posedge clk);
    link_rst <= 1'b0;
    @(posedge clk);
    rd(aer_pkg::CAP_CTRL_OFS, 32'h000000B3);
    rd(aer_pkg::HDR_LOG0_OFS, h.words[0]);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(aer_pkg::CAP_CTRL_OFS, 32'h000000A0);
    rd(aer_pkg::HDR_LOG0_OFS, 32'h0);
    // correctable events, then one masked
    for (int i = 0; i < 6; i++) begin
      u_err_source.fire(32'h0, 32'h1 << cb[i], h);
      rd(aer_pkg::COR_STATUS_OFS, 32'h1 << cb[i]);
      wr(aer_pkg::COR_STATUS_OFS, 32'h1 << cb[i]);
    end
    rd(aer_pkg::COR_STATUS_OFS, 32'h0);
    `CHK(n_cor, 6)
    wr(aer_pkg::COR_MASK_OFS, '1);
    u_err_source.fire(32'h0, 32'h1, h);
    rd(aer_pkg::COR_STATUS_OFS, 32'h1);
    `CHK(n_cor, 6)
    // interrupt held off by its enable, raised by it, dropped by clear
    wr(aer_pkg::IRQ_CLEAR_OFS, 32'h7);
    u_err_source.fire(32'h00080000, 32'h0, h);
    rd(aer_pkg::IRQ_STATUS_OFS, 32'h1);
    `CHK(irq, 1'b0)
    wr(aer_pkg::IRQ_ENABLE_OFS, 32'h1);
    `CHK(irq, 1'b1)
    wr(aer_pkg::IRQ_CLEAR_OFS, 32'h1);
    `CHK(irq, 1'b0)
    print_verdict();
  end
endmodule // advanced_error_reporting_regs_tb
